//--- dtm_pkg.sv
// shared constants for the dual temperature monitor core
package dtm_pkg;

  // register pointers
  localparam logic [7:0] PTR_LOCAL_TEMP    = 8'h00;
  localparam logic [7:0] PTR_REMOTE_HIGH   = 8'h01;
  localparam logic [7:0] PTR_STATUS        = 8'h02;
  localparam logic [7:0] PTR_CONFIG        = 8'h03;
  localparam logic [7:0] PTR_RATE          = 8'h04;
  localparam logic [7:0] PTR_LLIM_HIGH     = 8'h05;
  localparam logic [7:0] PTR_LLIM_LOW      = 8'h06;
  localparam logic [7:0] PTR_RLIM_HIGH_HI  = 8'h07;
  localparam logic [7:0] PTR_RLIM_LOW_HI   = 8'h08;
  localparam logic [7:0] PTR_REMOTE_LOW    = 8'h10;
  localparam logic [7:0] PTR_OFFSET_HIGH   = 8'h11;
  localparam logic [7:0] PTR_OFFSET_LOW    = 8'h12;
  localparam logic [7:0] PTR_RLIM_HIGH_LO  = 8'h13;
  localparam logic [7:0] PTR_RLIM_LOW_LO   = 8'h14;

  // status bit positions
  localparam int STAT_BUSY_BIT   = 7;
  localparam int STAT_LHIGH_BIT  = 6;
  localparam int STAT_LOCAL_BELOW_LIMIT_FLAG_BIT   = 5;
  localparam int STAT_RHIGH_BIT  = 4;
  localparam int STAT_REMOTE_BELOW_LIMIT_FLAG_BIT   = 3;

  // config bit positions
  localparam int CFG_MASK_BIT    = 7;
  localparam int CFG_STANDBY_SELECT_N_BIT    = 6;

  // reset values
  localparam logic [7:0]  TEMP_RESET_8    = 8'h80;
  localparam logic [10:0] TEMP_RESET_11   = 11'h400;
  localparam logic [7:0]  OFFSET_RESET    = 8'h00;
  localparam logic [7:0]  CONFIG_RESET    = 8'h00;
  localparam logic [7:0]  RATE_RESET      = 8'h02;
  localparam logic [7:0]  LLIM_HIGH_RESET = 8'h7F;
  localparam logic [7:0]  LLIM_LOW_RESET  = 8'h00;
  localparam logic [10:0] RLIM_HIGH_RESET = 11'h3F8;
  localparam logic [10:0] RLIM_LOW_RESET  = 11'h000;
  localparam logic [6:0]  SMB_ADDR_RESET  = 7'h00;

  // saturation bounds of an 11-bit signed code
  localparam logic [10:0] SAT_MAX_11 = 11'h3FF;
  localparam logic [10:0] SAT_MIN_11 = 11'h400;

  // cycle and sample counts, averaging shift
  localparam logic [1:0]  STRAP_SETTLE_CYC = 2'h3;
  localparam int          AVG_SAMPLES      = 16;
  localparam int          AVG_SHIFT        = 4;

  typedef enum logic [1:0] {
    CV_IDLE  = 2'b00,
    CV_START = 2'b01,
    CV_BUSY  = 2'b10,
    CV_WAIT  = 2'b11
  } dtm_conv_t;

  typedef enum logic [1:0] {
    SB_IDLE  = 2'b00,
    SB_ADDR  = 2'b01,
    SB_WRITE = 2'b10,
    SB_READ  = 2'b11
  } dtm_smb_t;

endpackage

//--- dtm_core.sv
// dual-channel temperature monitor core: converter sequencing, limits, smbus slave
`timescale 1ns/1ps
// Function
// - converter runs continuously, each conversion starts itself without host command.
// - conversions alternate local and remote, each stored in its own register.
// - local value keeps the upper seven result bits behind a zero top bit as one byte.
// - remote value is 11 bits, upper eight bits at pointer 0x01.
// - remote low three bits sit in bits 7:5 at 0x10, rest zero.
// - signed 11-bit offset at 0x11/0x12 is added to every remote result.
// - both offset registers reset to zero.
// - four limits, local 8-bit and remote 11-bit, compared against stored values.
// - each failed comparison sets its own channel and direction status flag.
// - alert pin pulled low while any out-of-limit flag is set and the alert mask bit is clear.
// - temperature values reset to the minus 128 degree code.
// - in normal mode first results are stored before the first comparison.
// - powering up in standby compares reset values, tripping both low flags.
// - host may leave standby then read status; clears only if in limits.
// - each reported value averages sixteen consecutive raw measurements per channel.
// - standby select high converts, low holds conversions stopped.
// - two three-state pins give the high and low address selection.
// - software sets standby, alert mask and conversion rate over the bus.
// - programmable registers are writable and every register is readable.
// - one result bit equals 0.125 degrees, remote range minus 128 to 127.875.
// - offset sum saturates at the largest and smallest codes.
module dtm_core
  import dtm_pkg::*;
#(
  parameter int RAW_W    = 10,
  parameter int GAP_BASE = 1000
) (
  // system
  input  wire logic             sys_clk,
  input  wire logic             rstn,
  // smbus link, scl clocks the link-side shifter
  input  wire logic             smb_scl,
  input  wire logic             smb_sda_i,
  output logic                  smb_sda_o,
  output logic                  smb_sda_oe,
  // alert, open drain
  output logic                  alert_o,
  output logic                  alert_oe,
  // pins
  input  wire logic             standby_select_n,
  input  wire logic [1:0]       addr_select_high,
  input  wire logic [1:0]       addr_select_low,
  // converter
  output logic                  adc_start,
  output logic                  adc_remote,
  input  wire logic             adc_done,
  input  wire logic [RAW_W-1:0] adc_data
);

  // three-state pin code to one address digit
  function automatic logic [1:0] pin_digit(input logic [1:0] code);
    pin_digit = code[1] ? 2'h2 : {1'b0, code[0]};
  endfunction
  // signed add with clamp to the 11-bit code range
  function automatic logic [10:0] sat_add11(input logic [10:0] a, input logic [10:0] b);
    logic signed [11:0] s;
    s = $signed({a[10], a}) + $signed({b[10], b});
    if (s[11] != s[10])
      sat_add11 = s[11] ? SAT_MIN_11 : SAT_MAX_11;
    else
      sat_add11 = s[10:0];
  endfunction
  logic [7:0] lk_shift_q;

  always_ff @(posedge smb_scl) begin
    lk_shift_q <= {lk_shift_q[6:0], smb_sda_i};
  end
  logic [1:0] scl_sy_q;
  logic [1:0] sda_sy_q;
  logic [1:0] standby_select_n_sy_q;
  logic [1:0] ahi_sy0_q;
  logic [1:0] ahi_sy1_q;
  logic [1:0] alo_sy0_q;
  logic [1:0] alo_sy1_q;
  logic       scl_p_q;
  logic       sda_p_q;
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      scl_sy_q  <= 2'h3;
      sda_sy_q  <= 2'h3;
      standby_select_n_sy_q <= 2'h3;
      ahi_sy0_q <= 2'h0;
      ahi_sy1_q <= 2'h0;
      alo_sy0_q <= 2'h0;
      alo_sy1_q <= 2'h0;
      scl_p_q   <= 1'b1;
      sda_p_q   <= 1'b1;
    end else begin
      scl_sy_q  <= {scl_sy_q[0], smb_scl};
      sda_sy_q  <= {sda_sy_q[0], smb_sda_i};
      standby_select_n_sy_q <= {standby_select_n_sy_q[0], standby_select_n};
      ahi_sy0_q <= addr_select_high;
      ahi_sy1_q <= ahi_sy0_q;
      alo_sy0_q <= addr_select_low;
      alo_sy1_q <= alo_sy0_q;
      scl_p_q   <= scl_sy_q[1];
      sda_p_q   <= sda_sy_q[1];
    end
  end
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  assign scl_s     = scl_sy_q[1];
  assign sda_s     = sda_sy_q[1];
  assign scl_rise  = scl_s & ~scl_p_q;
  assign scl_fall  = ~scl_s & scl_p_q;
  assign bus_start = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign bus_stop  = scl_s & scl_p_q & ~sda_p_q & sda_s;
  logic [1:0] strap_cnt_q;
  logic       ready_q;
  logic [6:0] smb_addr_q;
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      strap_cnt_q <= 2'h0;
      ready_q     <= 1'b0;
      smb_addr_q  <= SMB_ADDR_RESET;
    end else if (!ready_q) begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
      if (strap_cnt_q == STRAP_SETTLE_CYC) begin
        ready_q    <= 1'b1;
        smb_addr_q <= {3'b001, pin_digit(ahi_sy1_q), pin_digit(alo_sy1_q)};
      end
    end
  end
  logic [7:0]  local_q;
  logic [10:0] remote_q;
  logic [7:0]  off_hi_q;
  logic [2:0]  off_lo_q;
  logic [7:0]  config_q;
  logic [7:0]  rate_q;
  logic [7:0]  llim_hi_q;
  logic [7:0]  llim_lo_q;
  logic [10:0] rlim_hi_q;
  logic [10:0] rlim_lo_q;
  logic [3:0]  flags_q;
  logic        standby;
  logic        wr_en;
  logic [7:0]  wr_ptr;
  logic [7:0]  wr_data;
  assign standby = config_q[CFG_STANDBY_SELECT_N_BIT] | ~standby_select_n_sy_q[1];
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      off_hi_q  <= OFFSET_RESET;
      off_lo_q  <= OFFSET_RESET[2:0];
      config_q  <= CONFIG_RESET;
      rate_q    <= RATE_RESET;
      llim_hi_q <= LLIM_HIGH_RESET;
      llim_lo_q <= LLIM_LOW_RESET;
      rlim_hi_q <= RLIM_HIGH_RESET;
      rlim_lo_q <= RLIM_LOW_RESET;
    end else if (wr_en) begin
      unique case (wr_ptr)
        PTR_CONFIG:       config_q        <= wr_data;
        PTR_RATE:         rate_q          <= wr_data;
        PTR_LLIM_HIGH:    llim_hi_q       <= wr_data;
        PTR_LLIM_LOW:     llim_lo_q       <= wr_data;
        PTR_RLIM_HIGH_HI: rlim_hi_q[10:3] <= wr_data;
        PTR_RLIM_LOW_HI:  rlim_lo_q[10:3] <= wr_data;
        PTR_RLIM_HIGH_LO: rlim_hi_q[2:0]  <= wr_data[7:5];
        PTR_RLIM_LOW_LO:  rlim_lo_q[2:0]  <= wr_data[7:5];
        PTR_OFFSET_HIGH:  off_hi_q        <= wr_data;
        PTR_OFFSET_LOW:   off_lo_q        <= wr_data[7:5];
        default: ;
      endcase
    end
  end
  dtm_conv_t   cv_q;
  logic [3:0]  samp_cnt_q;
  logic [RAW_W+3:0] acc_q;
  logic [19:0] gap_cnt_q;
  logic        cmp_now_q;
  logic        init_cmp_q;
  logic [RAW_W-1:0] avg_w;
  logic [RAW_W+3:0] acc_w;
  assign acc_w = acc_q + {4'h0, adc_data};
  assign avg_w = acc_w[RAW_W+3:AVG_SHIFT];
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      cv_q       <= CV_IDLE;
      samp_cnt_q <= 4'h0;
      acc_q      <= '0;
      gap_cnt_q  <= 20'h0;
      adc_start  <= 1'b0;
      adc_remote <= 1'b0;
      local_q    <= TEMP_RESET_8;
      remote_q   <= TEMP_RESET_11;
      cmp_now_q  <= 1'b0;
      init_cmp_q <= 1'b1;
    end else begin
      adc_start <= 1'b0;
      cmp_now_q <= 1'b0;
      unique case (cv_q)
        CV_IDLE: begin
          if (ready_q) begin
            init_cmp_q <= 1'b0;
            cmp_now_q  <= init_cmp_q & standby;
            if (!standby)
              cv_q <= CV_START;
          end
        end
        CV_START: begin
          adc_start <= 1'b1;
          cv_q      <= CV_BUSY;
        end
        CV_BUSY: begin
          if (adc_done) begin
            samp_cnt_q <= samp_cnt_q + 4'h1;
            acc_q      <= acc_w;
            cv_q       <= CV_START;
            if (samp_cnt_q == 4'(AVG_SAMPLES - 1)) begin
              acc_q      <= '0;
              adc_remote <= ~adc_remote;
              if (adc_remote) begin
                // one lsb is 0.125 degrees
                remote_q  <= sat_add11({1'b0, avg_w}, {off_hi_q, off_lo_q});
                cmp_now_q <= 1'b1;
                gap_cnt_q <= 20'(GAP_BASE) << rate_q[2:0];
                cv_q      <= CV_WAIT;
              end else begin
                local_q <= {1'b0, avg_w[RAW_W-1:RAW_W-7]};
              end
            end
          end
        end
        CV_WAIT: begin
          gap_cnt_q <= gap_cnt_q - 20'h1;
          if (gap_cnt_q == 20'h0)
            cv_q <= standby ? CV_IDLE : CV_START;
        end
      endcase
    end
  end
  logic [3:0] cond_w;
  logic       stat_rd;
  always_comb begin
    cond_w = 4'h0;
    cond_w[3] = $signed(local_q) > $signed(llim_hi_q);
    cond_w[2] = $signed(local_q) < $signed(llim_lo_q);
    cond_w[1] = $signed(remote_q) > $signed(rlim_hi_q);
    cond_w[0] = $signed(remote_q) < $signed(rlim_lo_q);
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      flags_q <= 4'h0;
    end else begin
      // set wins over the clear of a status read
      flags_q <= (flags_q & ~({4{stat_rd}} & ~cond_w))
               | ({4{cmp_now_q}} & cond_w);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      alert_o  <= 1'b0;
      alert_oe <= 1'b0;
      smb_sda_o <= 1'b0;
    end else begin
      alert_o  <= 1'b0;
      smb_sda_o <= 1'b0;
      alert_oe <= (|flags_q) & ~config_q[CFG_MASK_BIT];
    end
  end
  logic [7:0] rd_data;
  logic [7:0] rd_ptr;
  always_comb begin
    rd_data = 8'h00;
    unique case (rd_ptr)
      PTR_LOCAL_TEMP:   rd_data = local_q;
      PTR_REMOTE_HIGH:  rd_data = remote_q[10:3];
      PTR_REMOTE_LOW:   rd_data = {remote_q[2:0], 5'h00};
      PTR_STATUS: begin
        rd_data[STAT_BUSY_BIT]  = (cv_q != CV_IDLE);
        rd_data[STAT_LHIGH_BIT] = flags_q[3];
        rd_data[STAT_LOCAL_BELOW_LIMIT_FLAG_BIT]  = flags_q[2];
        rd_data[STAT_RHIGH_BIT] = flags_q[1];
        rd_data[STAT_REMOTE_BELOW_LIMIT_FLAG_BIT]  = flags_q[0];
      end
      PTR_CONFIG:       rd_data = config_q;
      PTR_RATE:         rd_data = rate_q;
      PTR_LLIM_HIGH:    rd_data = llim_hi_q;
      PTR_LLIM_LOW:     rd_data = llim_lo_q;
      PTR_RLIM_HIGH_HI: rd_data = rlim_hi_q[10:3];
      PTR_RLIM_LOW_HI:  rd_data = rlim_lo_q[10:3];
      PTR_RLIM_HIGH_LO: rd_data = {rlim_hi_q[2:0], 5'h00};
      PTR_RLIM_LOW_LO:  rd_data = {rlim_lo_q[2:0], 5'h00};
      PTR_OFFSET_HIGH:  rd_data = off_hi_q;
      PTR_OFFSET_LOW:   rd_data = {off_lo_q, 5'h00};
      default:          rd_data = 8'h00;
    endcase
  end
  dtm_smb_t   sb_q;
  logic [3:0] bit_cnt_q;
  logic       ack_q;
  logic       first_q;
  logic [7:0] ptr_q;
  logic [7:0] tx_q;
  logic       sda_oe_q;
  logic       wr_en_q;
  logic [7:0] wr_data_q;
  logic       stat_rd_q;
  logic       rw_q;
  assign rd_ptr  = ptr_q;
  assign wr_en   = wr_en_q;
  assign wr_ptr  = ptr_q;
  assign wr_data = wr_data_q;
  assign stat_rd = stat_rd_q;
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      sb_q      <= SB_IDLE;
      bit_cnt_q <= 4'h0;
      ack_q     <= 1'b0;
      first_q   <= 1'b0;
      ptr_q     <= 8'h00;
      tx_q      <= 8'h00;
      sda_oe_q  <= 1'b0;
      wr_en_q   <= 1'b0;
      wr_data_q <= 8'h00;
      stat_rd_q <= 1'b0;
      rw_q      <= 1'b0;
    end else begin
      wr_en_q   <= 1'b0;
      stat_rd_q <= 1'b0;
      if (bus_stop) begin
        sb_q     <= SB_IDLE;
        sda_oe_q <= 1'b0;
      end else if (bus_start) begin
        sb_q      <= SB_ADDR;
        bit_cnt_q <= 4'h0;
        ack_q     <= 1'b0;
        first_q   <= 1'b1;
        sda_oe_q  <= 1'b0;
      end else if (sb_q != SB_IDLE && scl_rise) begin
        bit_cnt_q <= (bit_cnt_q == 4'h8) ? 4'h0 : bit_cnt_q + 4'h1;
        if (bit_cnt_q == 4'h7) begin
          unique case (sb_q)
            SB_ADDR: begin
              rw_q <= lk_shift_q[0];
              if (lk_shift_q[7:1] == smb_addr_q)
                ack_q <= 1'b1;
              else
                sb_q <= SB_IDLE;
            end
            SB_WRITE: begin
              ack_q   <= 1'b1;
              first_q <= 1'b0;
              if (first_q)
                ptr_q <= lk_shift_q;
              else begin
                wr_en_q   <= 1'b1;
                wr_data_q <= lk_shift_q;
              end
            end
            default: ;
          endcase
        end else if (bit_cnt_q == 4'h8) begin
          ack_q <= 1'b0;
          if (sb_q == SB_ADDR) begin
            sb_q <= rw_q ? SB_READ : SB_WRITE;
            if (rw_q) begin
              tx_q      <= rd_data;
              stat_rd_q <= (ptr_q == PTR_STATUS);
            end
          end else if (sb_q == SB_READ) begin
            if (sda_s)
              sb_q <= SB_IDLE;
            else begin
              tx_q      <= rd_data;
              stat_rd_q <= (ptr_q == PTR_STATUS);
            end
          end
        end
      end else if (sb_q != SB_IDLE && scl_fall) begin
        if (bit_cnt_q == 4'h8)
          sda_oe_q <= ack_q;
        else if (sb_q == SB_READ)
          sda_oe_q <= ~tx_q[3'(4'h7 - bit_cnt_q)];
        else
          sda_oe_q <= 1'b0;
      end
    end
  end

  assign smb_sda_oe = sda_oe_q;

endmodule

//--- dtm_core_props.sv
// port assertions for the temperature monitor core
`timescale 1ns/1ps
module dtm_core_props
  import dtm_pkg::*;
#(
  parameter int GAP_BASE = 1000
) (
  // system
  input wire logic sys_clk,
  input wire logic rstn,
  // link
  input wire logic smb_scl,
  input wire logic smb_sda_o,
  input wire logic smb_sda_oe,
  // alert
  input wire logic alert_o,
  input wire logic alert_oe,
  // pins
  input wire logic standby_select_n,
  // converter
  input wire logic adc_start,
  input wire logic adc_remote,
  input wire logic adc_done
);
  // cycles spent with the standby pin low
  logic [9:0] standby_select_n_q;
  always_ff @(posedge sys_clk) begin
    if (!rstn || standby_select_n)
      standby_select_n_q <= 10'h000;
    else if (standby_select_n_q != 10'h3FF)
      standby_select_n_q <= standby_select_n_q + 10'h001;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  property p_sda_low;
    !smb_sda_o;
  endproperty
  a_sda_low: assert property (p_sda_low) else $error("sda level not low");
  property p_alert_low;
    !alert_o;
  endproperty
  a_alert_low: assert property (p_alert_low) else $error("alert level not low");
  property p_start_pulse;
    adc_start |=> !adc_start;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start too long");
  property p_next_start;
    adc_done ##1 $stable(adc_remote) |=> adc_start;
  endproperty
  a_next_start: assert property (p_next_start) else $error("no next start");
  property p_mux_cause;
    $changed(adc_remote) |-> $past(adc_done);
  endproperty
  a_mux_cause: assert property (p_mux_cause) else $error("channel switched early");
  property p_pair_gap;
    $fell(adc_remote) |-> !adc_start [*8];
  endproperty
  a_pair_gap: assert property (p_pair_gap) else $error("no gap after pair");
  property p_sda_hold;
    smb_scl && $past(smb_scl) |-> $stable(smb_sda_oe);
  endproperty
  a_sda_hold: assert property (p_sda_hold) else $error("sda moved in scl high");
  property p_standby_idle;
    standby_select_n_q == 10'h3FF |-> !adc_start;
  endproperty
  a_standby_idle: assert property (p_standby_idle) else $error("start in standby");
  c_alert: cover property ($rose(alert_oe));
  c_ack: cover property ($rose(smb_sda_oe));
  c_pair: cover property ($fell(adc_remote));
endmodule
bind dtm_core dtm_core_props #(.GAP_BASE(GAP_BASE)) dtm_core_props_i (
  .sys_clk, .rstn, .smb_scl, .smb_sda_o, .smb_sda_oe, .alert_o, .alert_oe,
  .standby_select_n, .adc_start, .adc_remote, .adc_done
);

//--- dtm_host.sv
// smbus host model: scl framing and the open-drain data line
`timescale 1ns/1ps
module dtm_host (
  // link
  output logic     smb_scl,
  output logic     smb_sda_i,
  input wire logic smb_sda_oe
);
  localparam int H = 100;
  logic lclk = 1'b0;
  logic drv = 1'b0;
  logic n;
  initial smb_scl = 1'b1;
  always #3 lclk = ~lclk;
  // pull-up unless either party pulls low
  assign smb_sda_i = ~(drv | smb_sda_oe);
  task automatic tk(input int c);
    repeat (c) @(posedge lclk);
  endtask
  task automatic sbit(input logic b, output logic r);
    tk(H / 2);
    drv = ~b;
    tk(H / 2);
    smb_scl = 1'b1;
    tk(H);
    r = smb_sda_i;
    smb_scl = 1'b0;
  endtask
  task automatic sbyte(input logic [7:0] v, output logic [7:0] r, output logic a);
    for (int i = 7; i >= 0; i--)
      sbit(v[i], r[i]);
    sbit(1'b1, a);
  endtask
  task automatic start;
    drv = 1'b0;
    tk(H / 2);
    smb_scl = 1'b1;
    tk(H / 2);
    drv = 1'b1;
    tk(H / 2);
    smb_scl = 1'b0;
  endtask
  task automatic stop;
    tk(H / 2);
    drv = 1'b1;
    tk(H / 2);
    smb_scl = 1'b1;
    tk(H / 2);
    drv = 1'b0;
    tk(H);
  endtask
  task automatic xfer(input logic [6:0] a, input logic [7:0] p, input logic [7:0] wd,
                      input logic rd, output logic [7:0] q, output logic [2:0] ak);
    start();
    sbyte({a, 1'b0}, q, ak[2]);
    sbyte(p, q, ak[1]);
    if (rd) begin
      start();
      sbyte({a, 1'b1}, q, ak[0]);
      sbyte(8'hFF, q, n);
    end else begin
      sbyte(wd, q, ak[0]);
    end
    stop();
  endtask
endmodule

//--- testbench.sv
// self-checking bench for the temperature monitor core
`timescale 1ns/1ps
module testbench
  import dtm_pkg::*;
;
  localparam logic [6:0] ADDR = 7'h14;
  logic        sys_clk = 1'b0;
  logic        rstn, smb_scl, smb_sda_i, smb_sda_oe, alert_oe, standby_select_n;
  logic        adc_start, adc_remote, adc_done;
  logic [1:0]  addr_select_high, addr_select_low;
  logic [9:0]  adc_data, raw_l, raw_r;
  logic [10:0] off, re;
  logic [7:0]  le, llh, d, ef;
  logic [2:0]  ak;
  logic [7:0]  tp [6] = '{8'h00, 8'h01, 8'h10, 8'h11, 8'h12, 8'h20};
  logic [7:0]  te [6] = '{8'h80, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00};
  int          cv, seed, err_count, tests_run;
  always #25 sys_clk = ~sys_clk;
  dtm_core #(.GAP_BASE(4)) dtm_core_i (
    .sys_clk, .rstn, .smb_scl, .smb_sda_i, .smb_sda_o(), .smb_sda_oe, .alert_o(), .alert_oe,
    .standby_select_n, .addr_select_high, .addr_select_low, .adc_start, .adc_remote,
    .adc_done, .adc_data
  );
  dtm_host dtm_host_i (.smb_scl, .smb_sda_i, .smb_sda_oe);
  // converter answers three cycles after each start
  always @(posedge sys_clk) begin
    #1;
    adc_done = (cv == 1);
    adc_data = adc_remote ? raw_r : raw_l;
    if (adc_start)
      cv = 3;
    else if (cv > 0)
      cv = cv - 1;
  end
  task automatic complete_run;
    $display("errors %0d checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic rd(input logic [7:0] p);
    dtm_host_i.xfer(ADDR, p, 8'h00, 1'b1, d, ak);
    chk("ack", ak, 3'b000);
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] v);
    dtm_host_i.xfer(ADDR, p, v, 1'b0, d, ak);
    chk("ack", ak, 3'b000);
  endtask
  // waits for n completed local/remote pairs
  task automatic pairs(input int n);
    int c;
    logic pv;
    c = 0;
    pv = adc_remote;
    repeat (20000) begin
      @(posedge sys_clk);
      if (pv && !adc_remote)
        c++;
      pv = adc_remote;
      if (c == n)
        return;
    end
    err_count++;
    complete_run();
  endtask
  function automatic logic [10:0] rem_exp(input logic [9:0] r, input logic [10:0] o);
    logic [11:0] s;
    s = {2'b00, r} + {o[10], o};
    return (!s[11] && s[10]) ? SAT_MAX_11 : s[10:0];
  endfunction
  initial begin
    seed = 32'hBDF1;
    err_count = 0;
    tests_run = 0;
    cv = 0;
    rstn = 1'b0;
    standby_select_n = 1'b0;
    addr_select_high = 2'b01;
    addr_select_low = 2'b00;
    adc_done = 1'b0;
    adc_data = 10'h000;
    raw_l = 10'h100;
    raw_r = 10'h200;
    repeat (4) @(posedge sys_clk);
    #1 rstn = 1'b1;
    repeat (20) @(posedge sys_clk);
    chk("alert", alert_oe, 1'b1);
    foreach (tp[i]) begin
      rd(tp[i]);
      chk("reset value", d, te[i]);
    end
    rd(PTR_STATUS);
    chk("status", d & 8'h78, 8'h28);
    wr(PTR_CONFIG, 8'h80);
    chk("alert", alert_oe, 1'b0);
    rd(PTR_CONFIG);
    chk("config", d, 8'h80);
    rd(PTR_STATUS);
    chk("status", d & 8'h78, 8'h28);
    wr(PTR_CONFIG, 8'h00);
    dtm_host_i.xfer(7'h15, PTR_CONFIG, 8'h80, 1'b0, d, ak);
    chk("nack", ak, 3'b111);
    chk("alert", alert_oe, 1'b1);
    wr(PTR_LLIM_LOW, TEMP_RESET_8);
    wr(PTR_RLIM_LOW_HI, TEMP_RESET_11[10:3]);
    rd(PTR_STATUS);
    rd(PTR_STATUS);
    chk("status", d & 8'h78, 8'h00);
    chk("alert", alert_oe, 1'b0);
    wr(PTR_LLIM_LOW, LLIM_LOW_RESET);
    wr(PTR_RLIM_LOW_HI, RLIM_LOW_RESET[10:3]);
    @(posedge sys_clk);
    #1 standby_select_n = 1'b1;
    pairs(2);
    rd(PTR_STATUS);
    rd(PTR_STATUS);
    chk("status", d & 8'h78, 8'h00);
    chk("alert", alert_oe, 1'b0);
    for (int k = 0; k < 6; k++) begin
      raw_l = $random(seed);
      raw_r = k == 0 ? 10'h3FF : $random(seed);
      off = k == 0 ? 11'h3FF : $random(seed);
      llh = $random(seed);
      le = {1'b0, raw_l[9:3]};
      if (llh == le)
        llh = llh + 8'h01;
      wr(PTR_OFFSET_HIGH, off[10:3]);
      wr(PTR_OFFSET_LOW, {off[2:0], 5'h00});
      wr(PTR_LLIM_HIGH, llh);
      pairs(2);
      rd(PTR_STATUS);
      pairs(1);
      re = rem_exp(raw_r, off);
      ef = {1'b0, $signed(le) > $signed(llh), 1'b0,
            $signed(re) > $signed(RLIM_HIGH_RESET), $signed(re) < 0, 3'b000};
      rd(PTR_LOCAL_TEMP);
      chk("local", d, le);
      rd(PTR_REMOTE_HIGH);
      chk("remote high", d, re[10:3]);
      rd(PTR_REMOTE_LOW);
      chk("remote low", d, {re[2:0], 5'h00});
      rd(PTR_OFFSET_LOW);
      chk("offset low", d, {off[2:0], 5'h00});
      rd(PTR_STATUS);
      chk("status", d & 8'h78, ef);
      chk("alert", alert_oe, |ef);
    end
    complete_run();
  end
endmodule
